//--- hdl/port_device.sv
// Notes on behaviour
// R1 - ports A,B mode bit 0 I/O, 1 address
// R2 - direction 1 output, 0 input; reset input
// R3 - output drives data out; read returns pin
// R4 - ports C,D no mode select; I/O default
// R5 - host keeps direction 0 on logic-array inputs
// R6 - address drives when mode bit and direction or array enable
// R7 - address nibble map follows host bus type
// R8 - non-multiplexed bus: address only on port B
// R9 - host boots internally before enabling address out
// R10 - address inputs, optionally latched by strobe
// R11 - port A data bus disables its I/O
// R12 - bit n is pin n; reset zero
// R13 - window cycles write and read back setup
// R14 - port D direction has three bits only
// R15 - A,B bits 7:4 drive 1 is open-drain
// R16 - A,B bits 3:0, D 2:0 fast slew
// R17 - array, data port, address in are static
// R18 - data out drives on direction or enable
// R19 - unimplemented bits ignore writes, read zero
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module port_device
	import port_pkg::*;
#(
	// stored configuration; the two pin masks hold one bit per pin, port p at bits p*8+7:p*8
	parameter logic [PIN_COUNT-1:0] PLD_OUT_MASK  = 32'h0000_0000,
	parameter logic [PIN_COUNT-1:0] ADDR_IN_MASK  = 32'h0000_0000,
	parameter logic                 ADDR_IN_LATCH = 1'b1,
	parameter logic                 DATA_PORT_A   = 1'b0,
	parameter host_bus_t            BUS_TYPE      = BUS_MUX8
) (
	// link to the host
	port_if.device                  io,
	// port pins
	input  wire logic [PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0]      pin_out,
	output logic [PIN_COUNT-1:0]      pin_oe_n,
	output logic [PIN_COUNT-1:0]      slew_fast,
	// logic-array terms
	input  wire logic [PIN_COUNT-1:0] pld_value,
	input  wire logic [PIN_COUNT-1:0] pld_oe,
	output logic [PIN_COUNT-1:0]      pld_in,
	output logic [PIN_COUNT-1:0]      addr_in_bits,
	// port A as data bus
	input  wire logic [7:0]           host_data_out,
	input  wire logic                 host_data_oe,
	output logic [7:0]                host_data_in
);

	////////////////////////////////////////////////////////////////////////////
	// port setup and data registers

	logic [7:0]        dir_reg  [PORT_COUNT];
	logic [7:0]        dir_next [PORT_COUNT];
	logic [7:0]        mode_reg [PORT_COUNT];
	logic [7:0]        mode_next[PORT_COUNT];
	logic [7:0]        drv_reg  [PORT_COUNT];
	logic [7:0]        drv_next [PORT_COUNT];
	logic [7:0]        dout_reg [PORT_COUNT];
	logic [7:0]        dout_next[PORT_COUNT];
	logic [7:0]        rdata_reg;
	logic [7:0]        rdata_next;
	logic              rvalid_reg;
	logic              rvalid_next;
	logic [ADDR_W-1:0] lat_addr_reg;
	logic [ADDR_W-1:0] lat_addr_next;
	reg_kind_t         acc_kind;
	logic [1:0]        acc_port;
	logic [7:0]        acc_mask;

	assign acc_kind = decode_kind(io.io_addr);
	assign acc_port = io.io_addr[1:0];
	assign acc_mask = impl_mask(acc_kind, acc_port);

	// host writes land on implemented bits only; reads are registered one cycle
	always_comb begin
		dir_next      = dir_reg;
		mode_next     = mode_reg;
		drv_next      = drv_reg;
		dout_next     = dout_reg;
		rdata_next    = rdata_reg;
		rvalid_next   = io.io_rd;
		lat_addr_next = lat_addr_reg;
		if (io.address_latch_strobe) begin
			lat_addr_next = io.sys_addr;
		end
		if (io.io_wr) begin // R13
			case (acc_kind)
				K_DATA_OUT:  dout_next[acc_port] = io.io_wdata & acc_mask; // R19
				K_DIRECTION: dir_next[acc_port]  = io.io_wdata & acc_mask; // R14
				K_MODE:      mode_next[acc_port] = io.io_wdata & acc_mask; // R4
				K_DRIVER:    drv_next[acc_port]  = io.io_wdata & acc_mask;
				default:     ;
			endcase
		end
		if (io.io_rd) begin
			case (acc_kind)
				K_DATA_IN:   rdata_next = (DATA_PORT_A && acc_port == PORT_A) ? 8'h00 // R11
						: pin_in[acc_port*8 +: 8] & acc_mask; // R3
				K_DATA_OUT:  rdata_next = dout_reg[acc_port]; // R18
				K_DIRECTION: rdata_next = dir_reg[acc_port];
				K_MODE:      rdata_next = mode_reg[acc_port];
				K_DRIVER:    rdata_next = drv_reg[acc_port];
				default:     rdata_next = 8'h00; // R19
			endcase
		end
	end

	// every setup register clears at power-up: all pins input, I/O mode, CMOS, slow
	always_ff @(posedge io.clk or posedge io.reset) begin
		if (io.reset) begin
			for (int p = 0; p < PORT_COUNT; p++) begin
				dir_reg[p]  <= REG_RESET; // R2 R12
				mode_reg[p] <= REG_RESET; // R1
				drv_reg[p]  <= REG_RESET;
				dout_reg[p] <= REG_RESET;
			end
			rdata_reg    <= 8'h00;
			rvalid_reg   <= 1'b0;
			lat_addr_reg <= 16'h0000;
		end else begin
			dir_reg      <= dir_next;
			mode_reg     <= mode_next;
			drv_reg      <= drv_next;
			dout_reg     <= dout_next;
			rdata_reg    <= rdata_next;
			rvalid_reg   <= rvalid_next;
			lat_addr_reg <= lat_addr_next;
		end
	end

	assign io.io_rdata  = rdata_reg;
	assign io.io_rvalid = rvalid_reg;

	////////////////////////////////////////////////////////////////////////////
	// latched address output mapping per port

	// returns {valid bits, address bits} for ports A and B
	function automatic logic [15:0] addr_map(input logic [1:0] port, input logic [15:0] a);
		logic [15:0] r;
		r = 16'h0000;
		if (port == PORT_A) begin
			unique case (BUS_TYPE)
				BUS_BURST8:  r = {8'hF0, a[7:4], 4'h0}; // R7
				BUS_MUX8:    r = {8'hFF, a[7:0]};
				BUS_PAGE:    r = 16'h0000;
				BUS_NONMUX8: r = 16'h0000; // R8
			endcase
		end else if (port == PORT_B) begin
			unique case (BUS_TYPE)
				BUS_BURST8:  r = {8'h0F, 4'h0, a[11:8]}; // R7
				BUS_PAGE:    r = {8'hFF, a[15:8]};
				BUS_MUX8:    r = {8'hFF, a[7:0]};
				BUS_NONMUX8: r = {8'hFF, a[7:0]}; // R8
			endcase
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin drivers, one slice per pin

	logic [PIN_COUNT-1:0] pin_out_next;
	logic [PIN_COUNT-1:0] oe_n_next;
	logic [PIN_COUNT-1:0] slew_next;
	logic [PIN_COUNT-1:0] addr_in_next;

	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		localparam int P = i / 8;
		localparam int B = i % 8;
		localparam logic IMPL  = (P != 3) || (B < 3);
		localparam logic DPORT = DATA_PORT_A && (P == 0);
		localparam logic OD_OK = ((P < 2) && (B >= 4)) || (P == 2);
		localparam logic SL_OK = ((P < 2) && (B < 4)) || ((P == 3) && (B < 3));
		logic [15:0] amap;
		logic        addr_drv;
		logic        pld_drv;
		logic        drive;
		logic        val;
		logic        od;

		// address out needs the mode bit, direction or an array enable, and a mapped pin
		always_comb begin
			amap     = addr_map(2'(P), lat_addr_reg);
			addr_drv = mode_reg[P][B] && (dir_reg[P][B] || pld_oe[i]) && amap[8+B]; // R1 R6
			pld_drv  = PLD_OUT_MASK[i] && pld_oe[i]; // R6 R18
			od       = OD_OK && drv_reg[P][B]; // R15
			if (DPORT) begin
				drive = host_data_oe; // R11
				val   = host_data_out[B];
			end else if (pld_drv) begin
				drive = 1'b1;
				val   = pld_value[i];
			end else if (addr_drv) begin
				drive = 1'b1;
				val   = amap[B];
			end else begin
				drive = dir_reg[P][B] || pld_oe[i]; // R2 R3 R18
				val   = dout_reg[P][B];
			end
			// open-drain releases the pin for a one; the pull-up supplies it
			pin_out_next[i] = val;
			oe_n_next[i]    = !(IMPL && drive && !(od && val));
			slew_next[i]    = SL_OK && drv_reg[P][B]; // R16
			addr_in_next[i] = ADDR_IN_MASK[i] && !DPORT; // R10
		end
	end

	// all pin-side outputs come from flops; a pin is safe (released) in reset
	always_ff @(posedge io.clk or posedge io.reset) begin
		if (io.reset) begin
			pin_out      <= 32'h0000_0000;
			pin_oe_n     <= 32'hFFFF_FFFF;
			slew_fast    <= 32'h0000_0000;
			pld_in       <= 32'h0000_0000;
			addr_in_bits <= 32'h0000_0000;
			host_data_in <= 8'h00;
		end else begin
			pin_out   <= pin_out_next;
			pin_oe_n  <= oe_n_next;
			slew_fast <= slew_next;
			pld_in    <= pin_in; // R17
			// address inputs follow the pins, or only move on the strobe
			if (!ADDR_IN_LATCH || io.address_latch_strobe) begin
				addr_in_bits <= pin_in & addr_in_next; // R10
			end
			host_data_in <= DATA_PORT_A ? pin_in[7:0] : 8'h00;
		end
	end

endmodule

//--- hdl/port_host.sv
`timescale 1ns/100ps
module port_host
	import port_pkg::*;
#(
	// pins used as logic-array inputs; their direction bits are held at zero
	parameter logic [PIN_COUNT-1:0] PLD_IN_MASK = 32'h0000_0000
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link to the device
	port_if.host             io
);

	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} host_state_t;

	////////////////////////////////////////////////////////////////////////////
	// APB side and window cycle engine

	host_state_t       state_reg, state_next;
	logic [8:0]        cmd_reg, cmd_next;
	logic [7:0]        wdata_reg, wdata_next;
	logic [7:0]        rdata_reg, rdata_next;
	logic [ADDR_W-1:0] sys_addr_reg, sys_addr_next;
	logic              strobe_reg, strobe_next;
	logic [31:0]       prdata_next;
	logic              pready_next;
	logic              pslverr_next;
	logic              wr_reg, wr_next;
	logic              rd_reg, rd_next;
	logic              access;
	logic [7:0]        keep_mask;

	// pready rises in the first access cycle: every transfer has no wait states
	assign access = psel && penable && pready;

	always_comb begin
		state_next    = state_reg;
		cmd_next      = cmd_reg;
		wdata_next    = wdata_reg;
		rdata_next    = rdata_reg;
		sys_addr_next = sys_addr_reg;
		strobe_next   = 1'b0;
		wr_next       = 1'b0;
		rd_next       = 1'b0;
		prdata_next   = prdata;
		pready_next   = psel && !penable;
		pslverr_next  = 1'b0;
		keep_mask     = ~PLD_IN_MASK[cmd_reg[1:0]*8 +: 8];
		if (psel && !penable) begin
			prdata_next = 32'h0000_0000;
			unique case (paddr)
				APB_COMMAND:  prdata_next = {23'h0, cmd_reg};
				APB_WDATA:    prdata_next = {24'h0, wdata_reg};
				APB_STATUS:   prdata_next = {31'h0, state_reg != S_IDLE};
				APB_RDATA:    prdata_next = {24'h0, rdata_reg};
				APB_SYS_ADDR: prdata_next = {16'h0, sys_addr_reg};
				default:      pslverr_next = 1'b1;
			endcase
		end
		if (access && pwrite) begin
			case (paddr)
				APB_WDATA: wdata_next = pwdata[7:0];
				APB_SYS_ADDR: begin
					sys_addr_next = pwdata[15:0];
					strobe_next   = 1'b1;
				end
				// a command while busy is dropped; software polls busy first
				APB_COMMAND: if (state_reg == S_IDLE) begin
					cmd_next   = pwdata[8:0];
					state_next = S_ISSUE;
				end
				default: ;
			endcase
		end
		unique case (state_reg)
			S_IDLE: ;
			S_ISSUE: begin // R13
				wr_next = cmd_reg[CMD_WRITE_BIT];
				rd_next = !cmd_reg[CMD_WRITE_BIT];
				// direction writes never make a logic-array input an output
				if (decode_kind(cmd_reg[7:0]) == K_DIRECTION) begin
					wdata_next = wdata_reg & keep_mask; // R5
				end
				state_next = cmd_reg[CMD_WRITE_BIT] ? S_IDLE : S_WAIT;
			end
			S_WAIT: if (io.io_rvalid) begin
				rdata_next = io.io_rdata;
				state_next = S_IDLE;
			end
		endcase
	end

	// the window cycle and mode/direction setup are issued by this engine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg    <= S_IDLE;
			cmd_reg      <= 9'h000;
			wdata_reg    <= 8'h00;
			rdata_reg    <= 8'h00;
			sys_addr_reg <= 16'h0000;
			strobe_reg   <= 1'b0;
			wr_reg       <= 1'b0;
			rd_reg       <= 1'b0;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cmd_reg      <= cmd_next;
			wdata_reg    <= wdata_next;
			rdata_reg    <= rdata_next;
			sys_addr_reg <= sys_addr_next;
			strobe_reg   <= strobe_next;
			wr_reg       <= wr_next; // R6
			rd_reg       <= rd_next;
			prdata       <= prdata_next;
			pready       <= pready_next;
			pslverr      <= pslverr_next;
		end
	end

	assign io.io_addr              = cmd_reg[7:0];
	assign io.io_wdata             = wdata_reg;
	assign io.io_wr                = wr_reg;
	assign io.io_rd                = rd_reg;
	assign io.sys_addr             = sys_addr_reg;
	assign io.address_latch_strobe = strobe_reg;

endmodule

//--- include/port_if.sv
`timescale 1ns/100ps
interface port_if (
	input wire logic clk,
	input wire logic reset
);
	import port_pkg::*;

	// io_register_window access
	logic [7:0]        io_addr;
	logic [7:0]        io_wdata;
	logic              io_wr;
	logic              io_rd;
	logic [7:0]        io_rdata;
	logic              io_rvalid;
	// host system address and its address_latch_strobe
	logic [ADDR_W-1:0] sys_addr;
	logic              address_latch_strobe;

	modport device (
		input  clk, reset, io_addr, io_wdata, io_wr, io_rd, sys_addr, address_latch_strobe,
		output io_rdata, io_rvalid
	);

	modport host (
		input  clk, reset, io_rdata, io_rvalid,
		output io_addr, io_wdata, io_wr, io_rd, sys_addr, address_latch_strobe
	);
endinterface

//--- include/port_pkg.sv
package port_pkg;

	// port geometry
	localparam int PORT_COUNT = 4;
	localparam int PORT_W     = 8;
	localparam int PIN_COUNT  = 32;
	localparam int ADDR_W     = 16;

	// port indices inside a register group
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam logic [1:0] PORT_D = 2'h3;

	// offsets in the io_register_window; the port index is added to the group base
	localparam logic [7:0] OFF_DATA_IN       = 8'h00;
	localparam logic [7:0] OFF_DATA_OUT      = 8'h04;
	localparam logic [7:0] OFF_DIRECTION     = 8'h08;
	localparam logic [7:0] OFF_MODE_SELECT   = 8'h0C;
	localparam logic [7:0] OFF_DRIVER_SELECT = 8'h10;
	localparam logic [7:0] OFF_GROUP_MASK    = 8'hFC;

	// reset value of every port setup register
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_D    = 8'h07;
	localparam logic [7:0] MASK_NONE = 8'h00;

	// controller registers on APB (byte addresses)
	localparam logic [11:0] APB_COMMAND  = 12'h000;
	localparam logic [11:0] APB_WDATA    = 12'h004;
	localparam logic [11:0] APB_STATUS   = 12'h008;
	localparam logic [11:0] APB_RDATA    = 12'h00C;
	localparam logic [11:0] APB_SYS_ADDR = 12'h010;
	localparam int CMD_WRITE_BIT = 8;
	localparam int STATUS_BUSY_BIT = 0;

	typedef enum logic [2:0] {
		K_DATA_IN,
		K_DATA_OUT,
		K_DIRECTION,
		K_MODE,
		K_DRIVER,
		K_NONE
	} reg_kind_t;

	// static host bus wiring, fixed by the stored configuration
	typedef enum logic [1:0] {
		BUS_BURST8,
		BUS_PAGE,
		BUS_MUX8,
		BUS_NONMUX8
	} host_bus_t;

	function automatic reg_kind_t decode_kind(input logic [7:0] offset);
		case (offset & OFF_GROUP_MASK)
			OFF_DATA_IN:       return K_DATA_IN;
			OFF_DATA_OUT:      return K_DATA_OUT;
			OFF_DIRECTION:     return K_DIRECTION;
			OFF_MODE_SELECT:   return K_MODE;
			OFF_DRIVER_SELECT: return K_DRIVER;
			default:           return K_NONE;
		endcase
	endfunction

	// implemented bits of one register; the rest ignore writes and read zero
	function automatic logic [7:0] impl_mask(input reg_kind_t kind, input logic [1:0] port);
		case (kind)
			K_NONE:  return MASK_NONE;
			K_MODE:  return (port == PORT_A || port == PORT_B) ? MASK_FULL : MASK_NONE;
			default: return (port == PORT_D) ? MASK_D : MASK_FULL;
		endcase
	endfunction

endpackage

//--- tb/config_io_port_modes_sva.sv
`timescale 1ns/100ps
module config_io_port_modes_sva (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// window link
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic       io_rvalid,
	input wire logic       address_latch_strobe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////
	// shadow of port A direction, so a read back has a known answer
	logic [7:0] dir_a_reg;
	logic [7:0] dir_a_next;
	always_comb begin
		dir_a_next = dir_a_reg;
		if (io_wr && io_addr == 8'h08)
			dir_a_next = io_wdata;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			dir_a_reg <= 8'h00;
		else
			dir_a_reg <= dir_a_next;
	end
	////////////////////////////////
	// read request at one offset, and its answer
	sequence rd_at(logic [7:0] off);
		io_rd && io_addr == off;
	endsequence
	sequence answered;
		io_rvalid;
	endsequence
	chk_read_answered: assert property (io_rd |=> answered)
		else $error("window read not answered");
	chk_answer_cause: assert property (io_rvalid |-> $past(io_rd))
		else $error("answer without read");
	chk_no_overlap: assert property (!(io_wr && io_rd))
		else $error("write and read together");
	chk_write_pulse: assert property (io_wr |=> !io_wr)
		else $error("write strobe held");
	chk_strobe_pulse: assert property (address_latch_strobe |=> !address_latch_strobe)
		else $error("latch strobe held");
	chk_dir_readback: assert property (rd_at(8'h08) |=> io_rdata == dir_a_reg)
		else $error("direction read back wrong");
	chk_d_dir_bits: assert property (rd_at(8'h0B) |=> io_rdata[7:3] == 5'h00)
		else $error("port D direction high bits set");
	chk_cd_no_mode: assert property (rd_at(8'h0E) or rd_at(8'h0F) |=> io_rdata == 8'h00)
		else $error("port C or D mode not zero");
	chk_unmapped_zero: assert property (io_rd && io_addr >= 8'h14 |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule

//--- tb/tb_config_io_port_modes.sv
`timescale 1ns/100ps
module tb_config_io_port_modes;
	import port_pkg::*;
	logic        clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [31:0] seed;
	logic [31:0] pin_in;
	logic [31:0] pin_out;
	logic [31:0] pin_oe_n;
	logic [31:0] slew_fast;
	logic [31:0] pld_value;
	logic [31:0] pld_oe;
	logic [31:0] pld_in;
	logic [31:0] pin_out_nm;
	logic [31:0] pin_oe_n_nm;
	logic [31:0] addr_in_nm;
	logic [7:0]  host_data_in_nm;
	logic        host_data_oe;
	logic [7:0]  host_data_out;
	logic [7:0]  v;
	logic [7:0]  d;
	int          n_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	// pin 7 of port A feeds the logic arrays, so the host keeps it an input
	localparam logic [31:0] PLD_IN = 32'h0000_0080;
	////////////////////////////////
	// two ends joined by the interface
	port_if u_if (.clk(clk), .reset(reset));
	port_host #(.PLD_IN_MASK(PLD_IN)) u_port_host (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .io(u_if));
	port_device u_port_device (.io(u_if), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .slew_fast(slew_fast), .pld_value(pld_value),
		.pld_oe(pld_oe), .pld_in(pld_in), .addr_in_bits(), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .host_data_in());
	// a second device on a non-multiplexed bus listens to the same window cycles
	port_if u_if_nm (.clk(clk), .reset(reset));
	assign u_if_nm.io_addr              = u_if.io_addr;
	assign u_if_nm.io_wdata             = u_if.io_wdata;
	assign u_if_nm.io_wr                = u_if.io_wr;
	assign u_if_nm.io_rd                = u_if.io_rd;
	assign u_if_nm.sys_addr             = u_if.sys_addr;
	assign u_if_nm.address_latch_strobe = u_if.address_latch_strobe;
	port_device #(.ADDR_IN_MASK(32'h000F_0000), .DATA_PORT_A(1'b1), .BUS_TYPE(BUS_NONMUX8))
		u_port_device_nm (.io(u_if_nm), .pin_in(pin_in), .pin_out(pin_out_nm),
		.pin_oe_n(pin_oe_n_nm), .slew_fast(), .pld_value(pld_value), .pld_oe(pld_oe),
		.pld_in(), .addr_in_bits(addr_in_nm), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .host_data_in(host_data_in_nm));
	config_io_port_modes_sva u_sva (.clk(clk), .reset(reset), .io_addr(u_if.io_addr),
		.io_wdata(u_if.io_wdata), .io_wr(u_if.io_wr), .io_rd(u_if.io_rd),
		.io_rdata(u_if.io_rdata), .io_rvalid(u_if.io_rvalid),
		.address_latch_strobe(u_if.address_latch_strobe));
	////////////////////////////////
	// clock, and a cycle ceiling far above the under two thousand cycles used
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			report_and_stop;
		end
	end
	////////////////////////////////
	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; waits on pready, no fixed latency assumed
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one window cycle through the controller; result left in rd
	task win(input logic wr, input logic [7:0] off, input logic [7:0] dat);
		apb(1'b1, APB_WDATA, {24'h0, dat});
		apb(1'b1, APB_COMMAND, {23'h0, wr, off});
		rd = 32'h1;
		while (rd[STATUS_BUSY_BIT] !== 1'b0)
			apb(1'b0, APB_STATUS, 32'h0);
		apb(1'b0, APB_RDATA, 32'h0);
	endtask
	// implemented bits: kind 0 data out, 1 direction, 2 mode, 3 driver
	function automatic logic [7:0] msk(input int k, input int p);
		logic [7:0] m;
		m = (p == 3) ? 8'h07 : 8'hFF;
		if (k == 2)
			m = (p < 2) ? 8'hFF : 8'h00;
		if (k == 1)
			m = m & ~PLD_IN[p*8 +: 8];
		return m;
	endfunction
	////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h54CB;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pin_in = $random(seed);
		pld_value = $random(seed);
		host_data_out = 8'($random(seed));
		pld_oe = 32'h0000_0000;
		host_data_oe = 1'b1;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check(pin_oe_n, 32'hFFFF_FFFF);
		// pass 0 reads reset values, later passes random write and read back
		for (int n = 0; n < 4; n++)
			for (int k = 0; k < 4; k++)
				for (int p = 0; p < 4; p++) begin
					v = (n == 0) ? 8'h00 : 8'($random(seed));
					if (n > 0)
						win(1'b1, 8'(4 + 4 * k + p), v);
					win(1'b0, 8'(4 + 4 * k + p), 8'h00);
					check(rd, {24'h0, v & msk(k, p)});
				end
		win(1'b0, 8'h14, 8'h00);
		check(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		check({31'h0, err}, 32'h1);
		// host I/O mode on port A, push-pull
		d = 8'($random(seed));
		v = 8'($random(seed));
		win(1'b1, 8'h0C, 8'h00);
		win(1'b1, 8'h10, 8'h00);
		win(1'b1, 8'h08, d);
		win(1'b1, 8'h04, v);
		check(32'(pin_oe_n[7:0]), {24'h0, ~(d & msk(1, 0))});
		check(32'(pin_out[7:0] & d), 32'(v & d));
		win(1'b0, 8'h01, 8'h00);
		check(32'(rd[7:0]), 32'(pin_in[15:8]));
		// open drain on high nibble releases a driven one
		win(1'b1, 8'h10, 8'hF0);
		win(1'b1, 8'h04, 8'h50);
		win(1'b1, 8'h08, 8'hFF);
		check(32'(pin_oe_n[7:0]), {24'h0, 8'h50 | ~msk(1, 0)});
		win(1'b0, 8'h08, 8'h00);
		check(rd, {24'h0, msk(1, 0)});
		win(1'b1, 8'h11, 8'h0F);
		win(1'b1, 8'h13, 8'hFF);
		check(32'(slew_fast[15:0]), 32'h0F00);
		check(32'(slew_fast[26:24]), 32'h7);
		// address out needs both mode and direction set before any address is used
		win(1'b1, 8'h10, 8'h00);
		win(1'b1, 8'h11, 8'h00);
		win(1'b1, 8'h0C, 8'hFF);
		win(1'b1, 8'h0D, 8'hFF);
		win(1'b1, 8'h09, 8'h00);
		check(32'(pin_oe_n[15:8]), 32'hFF);
		win(1'b1, 8'h09, 8'hFF);
		rd = $random(seed);
		v = rd[7:0];
		apb(1'b1, APB_SYS_ADDR, {16'h0, rd[15:0]});
		apb(1'b0, APB_STATUS, 32'h0);
		apb(1'b0, APB_STATUS, 32'h0);
		check(32'(pin_oe_n[15:8]), 32'h00);
		check(32'(pin_out[15:8]), 32'(v));
		check(32'(pin_out[7:0] & msk(1, 0)), 32'(v & msk(1, 0)));
		check(32'(pin_out_nm[15:8]), 32'(v));
		check(32'(pin_oe_n_nm[15:8]), 32'h00);
		check(32'(pin_out_nm[7:0]), 32'(host_data_out));
		check(32'(pin_oe_n_nm[7:0]), 32'h00);
		check(addr_in_nm, pin_in & 32'h000F_0000);
		// latched address inputs hold between strobes; array inputs follow the pins
		pin_in <= ~pin_in;
		apb(1'b0, APB_STATUS, 32'h0);
		check(addr_in_nm, ~pin_in & 32'h000F_0000);
		check(pld_in, pin_in);
		check(32'(host_data_in_nm), 32'(pin_in[7:0]));
		// an array output enable drives the data out register like a direction bit
		win(1'b1, 8'h0A, 8'h00);
		win(1'b1, 8'h12, 8'h00);
		win(1'b1, 8'h06, v);
		check(32'(pin_oe_n[23:16]), 32'hFF);
		pld_oe <= 32'h00FF_0000;
		apb(1'b0, APB_STATUS, 32'h0);
		check(32'(pin_oe_n[23:16]), 32'h00);
		check(32'(pin_out[23:16]), 32'(v));
		report_and_stop;
	end
endmodule
